/* common/thc_defines.svh */
// Constants of the track/hold trigger host: offsets, fields, counter words, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef THC_DEFINES_SVH
`define THC_DEFINES_SVH

// Register byte offsets
`define THC_CTRL_OFS 5'h00
`define THC_CMD_OFS 5'h04
`define THC_STAT_OFS 5'h08
`define THC_CFGW_OFS 5'h0C
`define THC_HOLDW_OFS 5'h10

// Control register width and reset; dwell register reset
`define THC_CTRL_W 9
`define THC_CTRL_RST 9'h000
`define THC_HOLDW_RST 16'h0010

// Command register bits
`define THC_CMD_TRACK 0
`define THC_CMD_HOLD 1
`define THC_CMD_HIZ 2
`define THC_CMD_CFG 3
`define THC_CMD_MEAS 4

// Status bit cleared by writing one
`define THC_STAT_REFUSED 4

// Board flavours
`define THC_FLV_CMD16 2'h0
`define THC_FLV_LAB 2'h1
`define THC_FLV_LOWC 2'h2

// Counter bus ports
`define THC_PORT_CMD 2'h0
`define THC_PORT_DATA 2'h1
`define THC_PORT_MODE 2'h2

// Counter words
`define THC_W_SEL_MODE2 16'hFF02
`define THC_W_HIZ 16'h0004
`define THC_W_CLR_FLIP 16'hFFE2
`define THC_W_FLIP_MODE 16'h0002
`define THC_W_SET_FLIP 16'hFFEA
`define THC_W_LAB_TRACK 16'h0070
`define THC_W_LAB_HOLD 16'h0078
`define THC_W_LOWC_TRACK 16'h00B0
`define THC_W_LOWC_HOLD 16'h00B8

// Configuration word layout
`define THC_CFG_CH_LSB 20
`define THC_CFG_UU_LSB 12

// Timing
`define THC_CLK_MHZ 50
`define THC_SEL_NS 200
`define THC_SEL_CYC ((`THC_SEL_NS * `THC_CLK_MHZ + 999) / 1000)
`define THC_SER_DIV 4

`endif

/* common/thc_pkg.sv */
// Types of the track/hold trigger host.
// Assumes thc_defines.svh on the include path.
`include "thc_defines.svh"
package thc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CFG = 3'h1,
        ST_CNT = 3'h3,
        ST_WAIT = 3'h2,
        ST_SEL = 3'h6
    } thc_state_t;

    typedef enum logic [1:0] {
        ACT_TRACK = 2'h0,
        ACT_HOLD = 2'h1,
        ACT_HIZ = 2'h2
    } thc_act_t;

    // One write to the acquisition board's counter
    typedef struct packed {
        logic vld;
        logic [1:0] port;
        logic [15:0] word;
    } thc_cnt_op_t;

    // Control register layout
    typedef struct packed {
        logic [1:0] user_option_bits;
        logic [2:0] channel_select_field;
        logic mux;
        logic edge_mode;
        logic [1:0] flavor;
    } thc_ctrl_t;
endpackage

/* hdl/thc_axil.sv */
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the owner answers rd_data/rd_err combinationally from rd_addr.
`timescale 1ns/1ps
module thc_axil (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [4:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [4:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [4:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [4:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    logic aw_got_reg;
    logic w_got_reg;
    logic [3:0] strb_reg;

    // Read decode follows the offered address
    assign rd_addr = araddr;

    // Address and data capture, either order; slots free again once the response is taken
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            wr_addr <= 5'h00;
            wr_data <= 32'h00000000;
            strb_reg <= 4'h0;
        end else if (bvalid && bready) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
        end else begin
            if (awvalid && awready) begin
                aw_got_reg <= 1'b1;
                awready <= 1'b0;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_reg <= 1'b1;
                wready <= 1'b0;
                wr_data <= wdata;
                strb_reg <= wstrb;
            end
        end
    end

    // Write commit and response; partial strobes drop the write and answer SLVERR
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_en <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            wr_en <= 1'b0;
            if (aw_got_reg && w_got_reg && !bvalid && !wr_en) begin
                wr_en <= (strb_reg == 4'hF);
                bvalid <= 1'b1;
                bresp <= (strb_reg == 4'hF) ? 2'h0 : 2'h2;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            arready <= 1'b0;
            rdata <= rd_err ? 32'h00000000 : rd_data;
            rresp <= rd_err ? 2'h2 : 2'h0;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule

/* hdl/thc_host.sv */
// Host that drives the sample-freeze input of an eight-channel track/hold module:
// counter-word sequencer, trigger pin, module select and serial configuration.
// Assumes software on AXI4-Lite; TIMER_OUTPUT_PIN_I is an asynchronous readback of the pin.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "thc_defines.svh"
module thc_host #(
    parameter int SEL_CYC = `THC_SEL_CYC,
    parameter int SER_DIV = `THC_SER_DIV
) (
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic [4:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [4:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic TIMER_OUTPUT_PIN_O,
    output logic TIMER_OUTPUT_PIN_OE,
    input wire logic TIMER_OUTPUT_PIN_I,
    output logic MOD_SEL_N,
    output logic SER_DATA,
    output logic SER_CLK,
    output logic SER_SEL,
    output logic [15:0] CNT_WORD,
    output logic [1:0] CNT_PORT,
    output logic CNT_WR,
    output logic SAMPLE_STB
);
    logic wr_en;
    logic [4:0] wr_addr;
    logic [31:0] wr_data;
    logic [4:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    thc_pkg::thc_ctrl_t ctrl_reg;
    logic [15:0] hold_wait_reg;
    logic refused_reg;
    logic refused_next;
    logic flip_ready_reg;
    logic hold_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    thc_pkg::thc_state_t state_reg;
    thc_pkg::thc_act_t act_reg;
    logic meas_reg;
    logic [1:0] step_reg;
    logic gap_reg;
    logic [31:0] cfg_word_reg;
    logic [5:0] bit_reg;
    logic phase_reg;
    logic [7:0] div_reg;
    logic [15:0] wait_reg;
    logic [15:0] sel_reg;
    logic cmd_wr;
    logic [4:0] cmd;
    logic cmd_ok;
    thc_pkg::thc_cnt_op_t op;

    // Counter writes for one action; vld low marks the end
    function automatic thc_pkg::thc_cnt_op_t seq_op(input logic [1:0] flv,
            input thc_pkg::thc_act_t act, input logic ready, input logic [1:0] idx);
        thc_pkg::thc_cnt_op_t r;
        r = '0;
        if (flv == `THC_FLV_CMD16) begin
            unique case (act)
                thc_pkg::ACT_HIZ: begin
                    if (idx == 2'h0) r = '{1'b1, `THC_PORT_CMD, `THC_W_SEL_MODE2};
                    if (idx == 2'h1) r = '{1'b1, `THC_PORT_DATA, `THC_W_HIZ};
                end
                // drive low; later tracks only clear the flip
                thc_pkg::ACT_TRACK: begin
                    if (idx == 2'h0) r = '{1'b1, `THC_PORT_CMD, `THC_W_CLR_FLIP};
                    if (idx == 2'h1 && !ready) r = '{1'b1, `THC_PORT_CMD, `THC_W_SEL_MODE2};
                    if (idx == 2'h2 && !ready) r = '{1'b1, `THC_PORT_DATA, `THC_W_FLIP_MODE};
                end
                thc_pkg::ACT_HOLD: begin
                    if (idx == 2'h0) r = '{1'b1, `THC_PORT_CMD, `THC_W_SET_FLIP};
                end
                default: r = '0;
            endcase
        end else if (idx == 2'h0 && act != thc_pkg::ACT_HIZ) begin
            if (flv == `THC_FLV_LAB) begin
                r = '{1'b1, `THC_PORT_MODE,
                      (act == thc_pkg::ACT_HOLD) ? `THC_W_LAB_HOLD : `THC_W_LAB_TRACK};
            end else begin
                r = '{1'b1, `THC_PORT_MODE,
                      (act == thc_pkg::ACT_HOLD) ? `THC_W_LOWC_HOLD : `THC_W_LOWC_TRACK};
            end
        end
        return r;
    endfunction

    // Whether an action is possible on this board in this state
    function automatic logic act_ok(input logic [1:0] flv,
            input thc_pkg::thc_act_t act, input logic ready);
        logic r;
        r = 1'b1;
        if (flv == `THC_FLV_LAB || flv == `THC_FLV_LOWC) r = (act != thc_pkg::ACT_HIZ);
        else if (flv == `THC_FLV_CMD16) r = (act != thc_pkg::ACT_HOLD) || ready;
        else r = 1'b0;
        return r;
    endfunction

    thc_axil u_axil (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    assign cmd_wr = wr_en && (wr_addr == `THC_CMD_OFS);
    assign cmd = wr_data[4:0];
    assign op = seq_op(ctrl_reg.flavor, act_reg, flip_ready_reg, step_reg);

    // Command acceptance: idle, one bit set, action possible
    always_comb begin
        cmd_ok = (state_reg == thc_pkg::ST_IDLE) && ($countones(cmd) == 1);
        if (cmd[`THC_CMD_TRACK]) begin
            cmd_ok = cmd_ok && act_ok(ctrl_reg.flavor, thc_pkg::ACT_TRACK, 1'b0);
        end
        if (cmd[`THC_CMD_HOLD] || cmd[`THC_CMD_MEAS]) begin
            cmd_ok = cmd_ok && act_ok(ctrl_reg.flavor, thc_pkg::ACT_HOLD, flip_ready_reg);
        end
        if (cmd[`THC_CMD_HIZ]) cmd_ok = cmd_ok && act_ok(ctrl_reg.flavor, thc_pkg::ACT_HIZ, 1'b0);
    end

    // Register read decode
    always_comb begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        unique case (rd_addr)
            `THC_CTRL_OFS: rd_data = {23'h000000, ctrl_reg};
            `THC_CMD_OFS: rd_data = 32'h00000000;
            `THC_STAT_OFS: rd_data = {27'h0000000, refused_reg, pin_sync_reg, flip_ready_reg,
                                      hold_reg, state_reg != thc_pkg::ST_IDLE};
            `THC_CFGW_OFS: rd_data = cfg_word_reg;
            `THC_HOLDW_OFS: rd_data = {16'h0000, hold_wait_reg};
            default: rd_err = 1'b1;
        endcase
    end

    // Control and dwell registers, frozen while busy
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_reg <= `THC_CTRL_RST;
            hold_wait_reg <= `THC_HOLDW_RST;
        end else if (wr_en && state_reg == thc_pkg::ST_IDLE) begin
            if (wr_addr == `THC_CTRL_OFS) ctrl_reg <= wr_data[`THC_CTRL_W-1:0];
            if (wr_addr == `THC_HOLDW_OFS) hold_wait_reg <= wr_data[15:0];
        end
    end

    // Refused flag: a new refusal wins over the clear
    always_comb begin
        refused_next = refused_reg;
        if (wr_en && wr_addr == `THC_STAT_OFS && wr_data[`THC_STAT_REFUSED]) refused_next = 1'b0;
        if (cmd_wr && !cmd_ok) refused_next = 1'b1;
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) refused_reg <= 1'b0;
        else refused_reg <= refused_next;
    end

    // Pin readback synchroniser
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= TIMER_OUTPUT_PIN_I;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Sequencer state machine
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= thc_pkg::ST_IDLE;
            act_reg <= thc_pkg::ACT_TRACK;
            meas_reg <= 1'b0;
            step_reg <= 2'h0;
            gap_reg <= 1'b0;
            wait_reg <= 16'h0000;
            sel_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                thc_pkg::ST_IDLE: begin
                    step_reg <= 2'h0;
                    gap_reg <= 1'b0;
                    if (cmd_wr && cmd_ok) begin
                        meas_reg <= cmd[`THC_CMD_MEAS];
                        if (cmd[`THC_CMD_CFG] || cmd[`THC_CMD_MEAS]) begin
                            state_reg <= thc_pkg::ST_CFG;
                        end else begin
                            state_reg <= thc_pkg::ST_CNT;
                            if (cmd[`THC_CMD_HOLD]) act_reg <= thc_pkg::ACT_HOLD;
                            else if (cmd[`THC_CMD_HIZ]) act_reg <= thc_pkg::ACT_HIZ;
                            else act_reg <= thc_pkg::ACT_TRACK;
                        end
                    end
                end
                thc_pkg::ST_CFG: begin
                    if (bit_reg == 6'd32) begin
                        state_reg <= meas_reg ? thc_pkg::ST_CNT : thc_pkg::ST_IDLE;
                        act_reg <= thc_pkg::ACT_HOLD;
                    end
                end
                thc_pkg::ST_CNT: begin
                    gap_reg <= ~gap_reg;
                    if (!gap_reg && op.vld) begin
                        step_reg <= step_reg + 2'h1;
                    end else if (!gap_reg) begin
                        step_reg <= 2'h0;
                        if (act_reg == thc_pkg::ACT_HOLD && meas_reg) begin
                            state_reg <= thc_pkg::ST_WAIT;
                            wait_reg <= 16'h0000;
                        end else if (act_reg == thc_pkg::ACT_TRACK && ctrl_reg.edge_mode) begin
                            // release edge hold before next edge
                            state_reg <= thc_pkg::ST_SEL;
                            sel_reg <= 16'h0000;
                        end else begin
                            state_reg <= thc_pkg::ST_IDLE;
                        end
                    end
                end
                thc_pkg::ST_WAIT: begin
                    // sample after the dwell, then track
                    wait_reg <= wait_reg + 16'h0001;
                    if (wait_reg >= hold_wait_reg) begin
                        state_reg <= thc_pkg::ST_CNT;
                        act_reg <= thc_pkg::ACT_TRACK;
                        meas_reg <= 1'b0;
                        gap_reg <= 1'b0;
                    end
                end
                thc_pkg::ST_SEL: begin
                    sel_reg <= sel_reg + 16'h0001;
                    if (sel_reg == 16'(SEL_CYC - 1)) state_reg <= thc_pkg::ST_IDLE;
                end
                default: state_reg <= thc_pkg::ST_IDLE;
            endcase
        end
    end

    // Counter bus writes and resulting pin state
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            CNT_WR <= 1'b0;
            CNT_WORD <= 16'h0000;
            CNT_PORT <= 2'h0;
            TIMER_OUTPUT_PIN_O <= 1'b0;
            TIMER_OUTPUT_PIN_OE <= 1'b0;
            flip_ready_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            CNT_WR <= 1'b0;
            if (state_reg == thc_pkg::ST_CNT && !gap_reg && op.vld) begin
                CNT_WR <= 1'b1;
                CNT_WORD <= op.word;
                CNT_PORT <= op.port;
            end else if (state_reg == thc_pkg::ST_CNT && !gap_reg) begin
                // same pin levels serve either trigger mode
                TIMER_OUTPUT_PIN_OE <= (act_reg != thc_pkg::ACT_HIZ);
                TIMER_OUTPUT_PIN_O <= (act_reg == thc_pkg::ACT_HOLD);
                hold_reg <= (act_reg == thc_pkg::ACT_HOLD);
                flip_ready_reg <= (act_reg != thc_pkg::ACT_HIZ);
            end
        end
    end

    // Sample strobe at the end of the dwell
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) SAMPLE_STB <= 1'b0;
        else SAMPLE_STB <= (state_reg == thc_pkg::ST_WAIT) && (wait_reg >= hold_wait_reg);
    end

    // Module select pulse, low while releasing
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) MOD_SEL_N <= 1'b1;
        else MOD_SEL_N <= (state_reg != thc_pkg::ST_SEL);
    end

    // Serial configuration shifter, MSB first, clock idle high
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_word_reg <= 32'h00000000;
            bit_reg <= 6'd0;
            phase_reg <= 1'b0;
            div_reg <= 8'h00;
            SER_DATA <= 1'b0;
            SER_CLK <= 1'b1;
            SER_SEL <= 1'b0;
        end else if (state_reg == thc_pkg::ST_IDLE) begin
            bit_reg <= 6'd0;
            phase_reg <= 1'b0;
            div_reg <= 8'h00;
            SER_SEL <= 1'b0;
            SER_CLK <= 1'b1;
            if (cmd_wr && cmd_ok && (cmd[`THC_CMD_CFG] || cmd[`THC_CMD_MEAS])) begin
                // parallel word is zero, mux adds channel
                cfg_word_reg <= 32'h00000000;
                if (ctrl_reg.mux) begin
                    cfg_word_reg[`THC_CFG_CH_LSB +: 3] <= ctrl_reg.channel_select_field;
                end
                cfg_word_reg[`THC_CFG_UU_LSB +: 2] <= ctrl_reg.user_option_bits;
                SER_SEL <= 1'b1;
            end
        end else if (state_reg == thc_pkg::ST_CFG) begin
            div_reg <= div_reg + 8'h01;
            if (div_reg == 8'(SER_DIV - 1) && bit_reg != 6'd32) begin
                div_reg <= 8'h00;
                phase_reg <= ~phase_reg;
                if (!phase_reg) begin
                    SER_CLK <= 1'b0;
                    SER_DATA <= cfg_word_reg[5'd31 - bit_reg[4:0]];
                end else begin
                    SER_CLK <= 1'b1;
                    bit_reg <= bit_reg + 6'd1;
                end
            end
            // Falling select latches the word
            if (bit_reg == 6'd32) SER_SEL <= 1'b0;
        end
    end
endmodule

/* dv/thc_host_monitor.sv */
// Checker of the host's counter bus and trigger pin.
// Assumes binding onto thc_host.
`timescale 1ns/1ps
module thc_host_monitor (
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic TIMER_OUTPUT_PIN_O,
    input wire logic TIMER_OUTPUT_PIN_OE,
    input wire logic MOD_SEL_N,
    input wire logic [15:0] CNT_WORD,
    input wire logic [1:0] CNT_PORT,
    input wire logic CNT_WR,
    input wire logic SAMPLE_STB
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    logic [17:0] op;
    // Port and word of a strobed write
    assign op = {CNT_PORT, CNT_WORD} & {18{CNT_WR}};
    a_mode_hold: assert property (op[17:16] == 2'h2 && op[3] |-> ##[1:3] TIMER_OUTPUT_PIN_O)
        else $error("mode word did not raise pin");
    a_mode_track: assert property (op[17:16] == 2'h2 && !op[3]
            |-> ##[1:3] !TIMER_OUTPUT_PIN_O)
        else $error("mode word did not lower pin");
    a_set_flip: assert property (op == 18'h0FFEA |-> ##[1:3] TIMER_OUTPUT_PIN_O)
        else $error("set flip did not raise pin");
    a_clr_flip: assert property (op == 18'h0FFE2 |-> ##[1:6] !TIMER_OUTPUT_PIN_O)
        else $error("clear flip did not lower pin");
    a_hiz_data: assert property (op == 18'h10004 |-> ##[1:3] !TIMER_OUTPUT_PIN_OE)
        else $error("pin not released");
    a_flip_mode: assert property (op == 18'h10002
            |-> ##[1:3] TIMER_OUTPUT_PIN_OE && !TIMER_OUTPUT_PIN_O)
        else $error("pin not driven low");
    a_sel_track: assert property (!MOD_SEL_N |-> !TIMER_OUTPUT_PIN_O)
        else $error("select while trigger high");
    a_stb_hold: assert property (SAMPLE_STB |-> TIMER_OUTPUT_PIN_O && TIMER_OUTPUT_PIN_OE)
        else $error("sample outside hold");
endmodule
bind thc_host thc_host_monitor mon (.CLOCK(CLOCK), .ARST_N(ARST_N), .CNT_WR(CNT_WR),
    .TIMER_OUTPUT_PIN_O(TIMER_OUTPUT_PIN_O), .TIMER_OUTPUT_PIN_OE(TIMER_OUTPUT_PIN_OE),
    .MOD_SEL_N(MOD_SEL_N), .CNT_WORD(CNT_WORD), .CNT_PORT(CNT_PORT), .SAMPLE_STB(SAMPLE_STB));

/* dv/thc_module_model.sv */
// Behavioural track/hold module behind the trigger pin and serial link.
// Assumes a resolved pin level and the host's serial lines.
`timescale 1ns/1ps
module thc_module_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic edge_mode,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic sdat,
    input wire logic ssel,
    output logic hold,
    output logic [31:0] cfg
);
    logic [2:0] ts;
    logic [31:0] sh;
    logic pc;
    logic ps;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) ts <= 3'h0;
        else ts <= {ts[1:0], pin};
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) hold <= 1'b0;
        else if (!edge_mode) hold <= ts[1];
        else if (!sel_n) hold <= 1'b0;
        else if (ts[1] && !ts[2]) hold <= 1'b1;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) {pc, ps, sh, cfg} <= '0;
        else begin
            pc <= sclk;
            ps <= ssel;
            if (ssel && sclk && !pc) sh <= {sh[30:0], sdat};
            if (ps && !ssel) cfg <= sh;
        end
endmodule

/* dv/thc_host_test.sv */
// Self-checking bench of the track/hold trigger host.
// Assumes the host, its checker and the module model.
`timescale 1ns/1ps
module thc_host_test;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
    logic rry = 1'b0, tog = 1'b0, em = 1'b0, hs = 1'b0;
    logic [4:0] awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h0, rd, cfg;
    logic awr, wr, bv, arr, rv, o, oe, seln, sd, sc, ss, cwr, stb, hold;
    logic [1:0] rr, br, bres;
    logic [15:0] cw;
    logic [47:0] hist = '0;
    wire pin = oe ? o : tog;
    int failures = 0, samples_checked = 0;
    always #10 clk = ~clk;
    // Released pin wobbles; counter words and sample level recorded
    always @(posedge clk) begin
        tog <= ~tog;
        if (cwr) hist <= {hist[31:0], cw};
        if (stb) hs <= hold;
    end
    thc_host #(.SEL_CYC(2), .SER_DIV(2)) dut (.CLOCK(clk), .ARST_N(rst_n),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rry), .TIMER_OUTPUT_PIN_O(o), .TIMER_OUTPUT_PIN_OE(oe),
        .TIMER_OUTPUT_PIN_I(pin), .MOD_SEL_N(seln), .SER_DATA(sd), .SER_CLK(sc),
        .SER_SEL(ss), .CNT_WORD(cw), .CNT_PORT(), .CNT_WR(cwr), .SAMPLE_STB(stb));
    thc_module_model far (.clk(clk), .rst_n(rst_n), .pin(pin), .edge_mode(em), .sel_n(seln),
        .sclk(sc), .sdat(sd), .ssel(ss), .hold(hold), .cfg(cfg));
    task chk(input logic [47:0] s, input logic [47:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task axw(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        {awa, wd, awv, wv, bry} <= {a, d, 3'h7};
        // Each valid drops at the edge that takes it
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while ((awv && !awr) || (wv && !wr));
        while (bv !== 1'b1) @(posedge clk);
        bres = br;
        bry <= 1'b0;
    endtask
    task axr(input logic [4:0] a, output logic [47:0] d);
        @(posedge clk);
        {ara, arv, rry} <= {a, 2'h3};
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rry <= 1'b0;
        d = {14'h0, rr, rd};
    endtask
    task run(input logic [8:0] c, input logic [4:0] k);
        logic [47:0] s;
        em <= c[2];
        axw(5'h00, {23'h0, c});
        axw(5'h04, 32'h1 << k);
        s = 48'h1;
        for (int i = 0; i < 300 && s[0]; i++) axr(5'h08, s);
        chk(s & 48'h1, 48'h0);
        // Let the module model settle behind its pin synchroniser
        repeat (4) @(posedge clk);
    endtask
    task t_mode;
        logic [47:0] s;
        for (logic [8:0] f = 9'h1; f < 9'h3; f++) begin
            run(f, 5'h0);
            chk(hist & 48'hFF, f == 9'h1 ? 48'h70 : 48'hB0);
            chk({47'h0, hold}, 48'h0);
            run(f, 5'h1);
            chk(hist & 48'hFF, f == 9'h1 ? 48'h78 : 48'hB8);
            chk({47'h0, hold}, 48'h1);
        end
        axr(5'h14, s);
        chk(s, 48'h200000000);
        $display("board mode words done");
    endtask
    task t_cmd;
        run(9'h0, 5'h2);
        chk(hist & 48'hFFFFFFFF, 48'hFF020004);
        chk({47'h0, oe}, 48'h0);
        chk({46'h0, bres}, 48'h0);
        run(9'h0, 5'h0);
        chk(hist, 48'hFFE2FF020002);
        chk({46'h0, oe, o}, 48'h2);
        run(9'h0, 5'h1);
        chk(hist & 48'hFFFF, 48'hFFEA);
        chk({47'h0, hold}, 48'h1);
        run(9'h0, 5'h0);
        chk(hist & 48'hFFFF, 48'hFFE2);
        chk({47'h0, hold}, 48'h0);
        $display("command counter done");
    endtask
    task t_meas;
        run(9'h05D, 5'h4);
        chk({47'h0, hs}, 48'h1);
        chk({16'h0, cfg}, 48'h500000);
        chk({47'h0, hold}, 48'h0);
        run(9'h001, 5'h3);
        chk({16'h0, cfg}, 48'h0);
        $display("measure done");
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #400000;
        failures++;
        conclude;
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_mode;
        t_cmd;
        t_meas;
        conclude;
    end
endmodule
